// ==== rtl/aux_cal_pkg.sv ====
/*
  Constants for the auxiliary level and calibration register bank.
  Assumes an 8-bit register map reached over a 32-bit Avalon-MM slave.
*/
package aux_cal_pkg;
  // ----------------------------------------------------------------
  // Register indices and byte addresses (register index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_AUX_I_LEVEL_LOW   = 8'h0B;
  localparam logic [7:0] IDX_AUX_I_CONTROL     = 8'h0C;
  localparam logic [7:0] IDX_REFERENCE_TRIM    = 8'h0D;
  localparam logic [7:0] IDX_CAL_CONTROL       = 8'h0E;
  localparam logic [7:0] IDX_CAL_STATUS        = 8'h0F;
  localparam logic [7:0] IDX_COEF_ADDR         = 8'h10;
  localparam logic [7:0] IDX_COEF_DATA         = 8'h11;
  localparam logic [7:0] IDX_CAL_ACTION        = 8'h12;
  localparam int         ADDR_W                = 10;
  localparam logic [ADDR_W-1:0] OFS_AUX_I_LEVEL_LOW = {IDX_AUX_I_LEVEL_LOW, 2'b00};
  localparam logic [ADDR_W-1:0] OFS_AUX_I_CONTROL   = {IDX_AUX_I_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] OFS_REFERENCE_TRIM  = {IDX_REFERENCE_TRIM, 2'b00};
  localparam logic [ADDR_W-1:0] OFS_CAL_CONTROL     = {IDX_CAL_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] OFS_CAL_STATUS      = {IDX_CAL_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] OFS_COEF_ADDR       = {IDX_COEF_ADDR, 2'b00};
  localparam logic [ADDR_W-1:0] OFS_COEF_DATA       = {IDX_COEF_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] OFS_CAL_ACTION      = {IDX_CAL_ACTION, 2'b00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AUX_EN_BIT      = 7;
  localparam int AUX_SPAN_LSB    = 5;
  localparam int AUX_TOP_LSB     = 2;
  localparam int PRELOAD_Q_BIT   = 7;
  localparam int PRELOAD_I_BIT   = 6;
  localparam int SEL_Q_BIT       = 5;
  localparam int SEL_I_BIT       = 4;
  localparam int CAL_CLK_EN_BIT  = 3;
  localparam int DONE_Q_BIT      = 7;
  localparam int DONE_I_BIT      = 6;
  localparam int MEM_Q_LSB       = 2;
  localparam int MEM_I_LSB       = 0;
  localparam int ACT_DONE_CLR_Q  = 7;
  localparam int ACT_DONE_CLR_I  = 6;
  localparam int ACT_LAUNCH      = 4;
  localparam int ACT_STORE_WR    = 3;
  localparam int ACT_STORE_RD    = 2;
  localparam int ACT_CLEAR_Q     = 1;
  localparam int ACT_CLEAR_I     = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG8        = 8'h00;
  localparam logic [1:0] MEM_UNCAL       = 2'h0;
  localparam logic [1:0] MEM_SELF        = 2'h1;
  localparam logic [1:0] MEM_USER        = 2'h2;
  localparam logic [5:0] PRELOAD_FIXED   = 6'h20;
  localparam logic [5:0] USER_PRELOAD_AD = 6'h01;
  localparam int         CAL_STEPS       = 8;
  localparam int         DIV_W           = 8;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN  = 3'b010,
    CAL_DONE = 3'b100
  } cal_state_t;
endpackage : aux_cal_pkg

// ==== rtl/aux_cal_regs.sv ====
/*
  Auxiliary level, reference trim and self-calibration register bank.
  Assumes an Avalon-MM master on clk (40 MHz converter clock) and
  that the analog side consumes the decoded level and trim outputs.
*/
// Function
// - Level low byte register, reset zero
// - Ten-bit level code, zero at reset
// - Control bits 1:0 give level MSBs
// - Control bit 7 enables aux output
// - Bits 6:5 select output span
// - Bits 4:2 select top of range
// - Six-bit two's complement reference trim
// - Quad preload: fixed 32 or user
// - Inphase preload: fixed 32 or user
// - Bits 5:4 select channels for calibration
// - Bit 3 gates the calibration clock
// - Bits 2:0 set calibration clock divide
// - Status bits 7:6 report completion
// - Status bits 3:0 show memory state
// - Coefficient store address register
// - Coefficient store data register
// - Launch bit starts selected calibration
// - Store write and read strobes
// - Clear bits reset channel coefficients
`timescale 1ns/10ps
`default_nettype none
module aux_cal_regs
  import aux_cal_pkg::*;
#(
  parameter int STORE_DEPTH = 64,
  parameter int CAL_TICKS   = CAL_STEPS
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           resetn,
  // Avalon-MM slave
  input  wire logic [aux_cal_pkg::ADDR_W-1:0] address,
  input  wire logic                           read,
  input  wire logic                           write,
  input  wire logic [3:0]                     byteenable,
  input  wire logic [31:0]                    writedata,
  output logic      [31:0]                    readdata,
  output logic                                waitrequest,
  output logic      [1:0]                     response,
  // Auxiliary output controls
  output logic      [9:0]                     inphase_aux_level,
  output logic                                inphase_aux_output_enable,
  output logic      [1:0]                     inphase_aux_span_select,
  output logic      [2:0]                     inphase_aux_top_select,
  output logic      [5:0]                     reference_trim_code,
  // Calibration clock enable and active coefficients
  output logic                                cal_tick,
  output logic      [5:0]                     quad_coef,
  output logic      [5:0]                     inphase_coef
);
  import aux_cal_pkg::*;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle: request is taken on the second edge.
  logic       ack_q;
  logic       req;
  logic       wr_go;
  logic       rd_go;
  logic [7:0] wbyte;
  logic       hit;

  assign req         = read | write;
  assign waitrequest = req & ~ack_q;
  assign wr_go       = write & ack_q;
  assign rd_go       = read & ack_q;
  assign wbyte       = byteenable[0] ? writedata[7:0] : RST_REG8;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] level_low_q;
  logic [7:0] aux_ctl_q;
  logic [5:0] trim_q;
  logic [7:0] cal_ctl_q;
  logic [5:0] coef_addr_q;
  logic [5:0] coef_data_q;
  logic [7:0] act;
  logic [5:0] store_q [STORE_DEPTH];

  assign act = (wr_go && address == OFS_CAL_ACTION) ? wbyte : RST_REG8;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_low_q <= RST_REG8;
      aux_ctl_q   <= RST_REG8;
      trim_q      <= 6'h00;
      cal_ctl_q   <= RST_REG8;
      coef_addr_q <= 6'h00;
    end else if (wr_go && byteenable[0]) begin
      if (address == OFS_AUX_I_LEVEL_LOW) begin
        level_low_q <= wbyte;
      end else if (address == OFS_AUX_I_CONTROL) begin
        aux_ctl_q <= {wbyte[7:2], wbyte[1:0]};
      end else if (address == OFS_REFERENCE_TRIM) begin
        trim_q <= wbyte[5:0];
      end else if (address == OFS_CAL_CONTROL) begin
        cal_ctl_q <= wbyte;
      end else if (address == OFS_COEF_ADDR) begin
        coef_addr_q <= wbyte[5:0];
      end
    end
  end

  // Store read overrides a same-cycle data write: the strobe is newer.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      coef_data_q <= 6'h00;
    end else if (act[ACT_STORE_RD]) begin
      coef_data_q <= store_q[coef_addr_q];
    end else if (wr_go && byteenable[0] && address == OFS_COEF_DATA) begin
      coef_data_q <= wbyte[5:0];
    end
  end

  // Store holds only data, no reset, so it can map to RAM.
  always_ff @(posedge clk) begin
    if (act[ACT_STORE_WR]) begin
      store_q[coef_addr_q] <= coef_data_q;
    end
  end

  // ----------------------------------------------------------------
  // Auxiliary output decode
  // ----------------------------------------------------------------
  assign inphase_aux_level         = {aux_ctl_q[1:0], level_low_q};
  assign inphase_aux_output_enable = aux_ctl_q[AUX_EN_BIT];
  assign inphase_aux_span_select   = aux_ctl_q[AUX_SPAN_LSB +: 2];
  assign inphase_aux_top_select    = aux_ctl_q[AUX_TOP_LSB +: 3];
  assign reference_trim_code       = trim_q;

  // ----------------------------------------------------------------
  // Calibration clock divider
  // ----------------------------------------------------------------
  // Divide ratio is 256 >> code; tick is a one-cycle enable.
  logic [DIV_W-1:0] div_cnt_q;
  logic [DIV_W-1:0] div_last;
  logic             cal_clk_on;

  assign cal_clk_on = cal_ctl_q[CAL_CLK_EN_BIT];
  assign div_last   = DIV_W'((9'h100 >> cal_ctl_q[2:0]) - 9'h001);
  assign cal_tick   = cal_clk_on && (div_cnt_q >= div_last);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_q <= '0;
    end else if (!cal_clk_on || cal_tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + DIV_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Self-calibration sequencer
  // ----------------------------------------------------------------
  // Calibration runs a fixed number of ticks; the analog search is
  // outside this block, so coefficients hold the preload value.
  cal_state_t state_q;
  logic [7:0] tick_cnt_q;
  logic       run_q_q;
  logic       run_i_q;
  logic       finish;

  assign finish = (state_q == CAL_RUN) && cal_tick && (tick_cnt_q == 8'(CAL_TICKS - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= CAL_IDLE;
      tick_cnt_q <= 8'h00;
      run_q_q    <= 1'b0;
      run_i_q    <= 1'b0;
    end else begin
      case (state_q)
        CAL_IDLE: begin
          if (act[ACT_LAUNCH] && (cal_ctl_q[SEL_Q_BIT] || cal_ctl_q[SEL_I_BIT])) begin
            state_q    <= CAL_RUN;
            tick_cnt_q <= 8'h00;
            run_q_q    <= cal_ctl_q[SEL_Q_BIT];
            run_i_q    <= cal_ctl_q[SEL_I_BIT];
          end
        end
        CAL_RUN: begin
          if (finish) begin
            state_q <= CAL_DONE;
          end else if (cal_tick) begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
          end
        end
        CAL_DONE: begin
          state_q <= CAL_IDLE;
          run_q_q <= 1'b0;
          run_i_q <= 1'b0;
        end
        default: begin
          state_q <= CAL_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status and coefficients per channel
  // ----------------------------------------------------------------
  logic [1:0] done_q;
  logic [1:0] mem_q [2];
  logic [5:0] coef_q [2];
  logic [1:0] run_ch;
  logic [1:0] pre_sel;
  logic [1:0] clr_ch;
  logic [1:0] done_clr;

  assign run_ch   = {run_q_q, run_i_q};
  assign pre_sel  = {cal_ctl_q[PRELOAD_Q_BIT], cal_ctl_q[PRELOAD_I_BIT]};
  assign clr_ch   = {act[ACT_CLEAR_Q], act[ACT_CLEAR_I]};
  assign done_clr = {act[ACT_DONE_CLR_Q], act[ACT_DONE_CLR_I]};

  for (genvar c = 0; c < 2; c++) begin : g_chan
    // Done flag: a finish in the clearing cycle wins.
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        done_q[c] <= 1'b0;
      end else if (finish && run_ch[c]) begin
        done_q[c] <= 1'b1;
      end else if (done_clr[c] || (act[ACT_LAUNCH] && run_ch[c] == 1'b0 && state_q == CAL_IDLE
                   && (c == 1 ? cal_ctl_q[SEL_Q_BIT] : cal_ctl_q[SEL_I_BIT]))) begin
        done_q[c] <= 1'b0;
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        mem_q[c]  <= MEM_UNCAL;
        coef_q[c] <= PRELOAD_FIXED;
      end else if (finish && run_ch[c]) begin
        mem_q[c]  <= MEM_SELF;
        coef_q[c] <= pre_sel[c] ? store_q[USER_PRELOAD_AD] : PRELOAD_FIXED;
      end else if (clr_ch[c]) begin
        mem_q[c]  <= MEM_UNCAL;
        coef_q[c] <= PRELOAD_FIXED;
      end
    end
  end

  assign quad_coef    = coef_q[1];
  assign inphase_coef = coef_q[0];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rsel;
  always_comb begin
    hit  = 1'b1;
    rsel = RST_REG8;
    if (address == OFS_AUX_I_LEVEL_LOW) begin
      rsel = level_low_q;
    end else if (address == OFS_AUX_I_CONTROL) begin
      rsel = aux_ctl_q;
    end else if (address == OFS_REFERENCE_TRIM) begin
      rsel = {2'b00, trim_q};
    end else if (address == OFS_CAL_CONTROL) begin
      rsel = cal_ctl_q;
    end else if (address == OFS_CAL_STATUS) begin
      rsel = {done_q[1], done_q[0], 2'b00, mem_q[1], mem_q[0]};
    end else if (address == OFS_COEF_ADDR) begin
      rsel = {2'b00, coef_addr_q};
    end else if (address == OFS_COEF_DATA) begin
      rsel = {2'b00, coef_data_q};
    end else if (address == OFS_CAL_ACTION) begin
      rsel = RST_REG8;
    end else begin
      hit = 1'b0;
    end
  end

  // Read data registered in the wait cycle, valid at the taking edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
      response <= 2'b00;
    end else if (req && !ack_q) begin
      readdata <= read ? {24'h00_0000, rsel} : 32'h0000_0000;
      response <= hit ? 2'b00 : 2'b11;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  level_write_a: assert property (wr_go && byteenable[0] && address == OFS_AUX_I_LEVEL_LOW
    |=> inphase_aux_level[7:0] == $past(writedata[7:0])) else $error("level low not stored");
  level_msb_a: assert property (wr_go && byteenable[0] && address == OFS_AUX_I_CONTROL
    |=> inphase_aux_level[9:8] == $past(writedata[1:0])) else $error("level msbs not stored");
  enable_follow_a: assert property (wr_go && byteenable[0] && address == OFS_AUX_I_CONTROL
    |=> inphase_aux_output_enable == $past(writedata[AUX_EN_BIT])) else $error("enable not stored");
  divider_stop_a: assert property (!cal_clk_on |=> div_cnt_q == '0 && !cal_tick)
    else $error("divider not held while stopped");
  // A control write in the window moves the ratio, so it excuses the second tick
  divider_two_a: assert property (cal_clk_on && cal_ctl_q[2:0] == 3'h7 && cal_tick
    && $stable(cal_ctl_q) |=> !cal_tick ##1 (cal_tick || cal_ctl_q != $past(cal_ctl_q, 2)))
    else $error("divide by 2 wrong");
  launch_run_a: assert property (state_q == CAL_IDLE && act[ACT_LAUNCH] && cal_ctl_q[SEL_I_BIT]
    |=> state_q == CAL_RUN) else $error("launch ignored");
  finish_status_a: assert property (finish && run_i_q |=> done_q[0] && mem_q[0] == MEM_SELF)
    else $error("finish not reported");
  clear_coef_a: assert property (clr_ch[1] && !(finish && run_q_q) |=> mem_q[1] == MEM_UNCAL)
    else $error("clear failed");
  store_read_a: assert property (act[ACT_STORE_RD] |=> coef_data_q == $past(store_q[coef_addr_q]))
    else $error("store read wrong");
  wait_one_a: assert property (req && !ack_q |-> waitrequest ##1 (!waitrequest || !req))
    else $error("wait state wrong");

  launch_c: cover property (act[ACT_LAUNCH] ##[1:300] finish);
  store_c: cover property (act[ACT_STORE_WR] ##[1:20] act[ACT_STORE_RD]);
  bad_addr_c: cover property (rd_go && !hit);
endmodule : aux_cal_regs
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench for the auxiliary level and calibration register bank.
  Assumes an Avalon-MM slave on clk; the master waits out any wait states.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import aux_cal_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk;
  logic              resetn;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [3:0]        byteenable;
  logic [31:0]       writedata;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic [1:0]        response;
  logic [9:0]        inphase_aux_level;
  logic              inphase_aux_output_enable;
  logic [1:0]        inphase_aux_span_select;
  logic [2:0]        inphase_aux_top_select;
  logic [5:0]        reference_trim_code;
  logic              cal_tick;
  logic [5:0]        quad_coef;
  logic [5:0]        inphase_coef;
  int                failures;
  int                total_checks;
  int                cycle_count;

  // Short calibration keeps the run brief
  aux_cal_regs #(.STORE_DEPTH(64), .CAL_TICKS(2)) u_aux_cal_regs (
    .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .inphase_aux_level(inphase_aux_level),
    .inphase_aux_output_enable(inphase_aux_output_enable),
    .inphase_aux_span_select(inphase_aux_span_select), .inphase_aux_top_select(inphase_aux_top_select),
    .reference_trim_code(reference_trim_code), .cal_tick(cal_tick), .quad_coef(quad_coef),
    .inphase_coef(inphase_coef)
  );

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request holds until waitrequest is seen low at a rising edge; only the
  // bench timeout ends a hung wait
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    @(posedge clk);
    address   <= a;
    writedata <= {24'h0, d};
    write     <= wr;
    read      <= ~wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    rs = response;
    read  <= 1'b0;
    write <= 1'b0;
    // Outputs updated at the taking edge are compared once settled
    @(negedge clk);
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'b1, a, d, rd, rs);
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'b0, a, 8'h00, rd, rs);
    chk(rd, {24'h0, exp});
    chk(32'(rs), 32'h0);
  endtask : rdchk

  task automatic wait_done(input int bit_pos, output logic [31:0] rd);
    logic [1:0] rs;
    int         n;
    n = 0;
    do begin
      bus(1'b0, OFS_CAL_STATUS, 8'h00, rd, rs);
      n++;
    end while (rd[bit_pos] !== 1'b1 && n < 400);
  endtask : wait_done

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    rdchk(OFS_AUX_I_LEVEL_LOW, 8'h00);
    rdchk(OFS_AUX_I_CONTROL, 8'h00);
    rdchk(OFS_REFERENCE_TRIM, 8'h00);
    rdchk(OFS_CAL_CONTROL, 8'h00);
    rdchk(OFS_CAL_STATUS, 8'h00);
    rdchk(OFS_COEF_ADDR, 8'h00);
    rdchk(OFS_COEF_DATA, 8'h00);
    chk(32'(inphase_aux_level), 32'h0);
    chk(32'(quad_coef), 32'h20);
    chk(32'(inphase_coef), 32'h20);
  endtask : test_reset

  task automatic test_level;
    logic [9:0] codes [3];
    codes = '{10'h3FF, 10'h200, 10'h000};
    foreach (codes[i]) begin
      wr(OFS_AUX_I_LEVEL_LOW, codes[i][7:0]);
      wr(OFS_AUX_I_CONTROL, {6'h00, codes[i][9:8]});
      chk(32'(inphase_aux_level), 32'(codes[i]));
    end
    // Masked byte lane must not store
    @(posedge clk);
    byteenable <= 4'h0;
    wr(OFS_AUX_I_LEVEL_LOW, 8'hAA);
    @(posedge clk);
    byteenable <= 4'hF;
    rdchk(OFS_AUX_I_LEVEL_LOW, 8'h00);
  endtask : test_level

  task automatic test_control;
    logic [7:0] v;
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 5; t++) begin
        v = {1'b1, 2'(s), 3'(t), 2'b01};
        wr(OFS_AUX_I_CONTROL, v);
        chk(32'(inphase_aux_output_enable), 32'h1);
        chk(32'(inphase_aux_span_select), 32'(s));
        chk(32'(inphase_aux_top_select), 32'(t));
        rdchk(OFS_AUX_I_CONTROL, v);
      end
    end
    wr(OFS_AUX_I_CONTROL, 8'h00);
    chk(32'(inphase_aux_output_enable), 32'h0);
  endtask : test_control

  task automatic test_trim;
    logic [5:0] codes [3];
    codes = '{6'h1F, 6'h20, 6'h3F};
    foreach (codes[i]) begin
      wr(OFS_REFERENCE_TRIM, {2'b00, codes[i]});
      chk(32'(reference_trim_code), 32'(codes[i]));
      rdchk(OFS_REFERENCE_TRIM, {2'b00, codes[i]});
    end
  endtask : test_trim

  task automatic test_store;
    wr(OFS_COEF_ADDR, 8'h01);
    rdchk(OFS_COEF_ADDR, 8'h01);
    wr(OFS_COEF_DATA, 8'h15);
    rdchk(OFS_COEF_DATA, 8'h15);
    wr(OFS_CAL_ACTION, 8'h08);
    // Second location proves the address steers the access
    wr(OFS_COEF_ADDR, 8'h02);
    wr(OFS_COEF_DATA, 8'h2A);
    wr(OFS_CAL_ACTION, 8'h08);
    wr(OFS_COEF_ADDR, 8'h01);
    wr(OFS_COEF_DATA, 8'h00);
    wr(OFS_CAL_ACTION, 8'h04);
    rdchk(OFS_COEF_DATA, 8'h15);
  endtask : test_store

  task automatic test_cal;
    logic [31:0] rd;
    wr(OFS_CAL_CONTROL, 8'hFF);
    wr(OFS_CAL_ACTION, 8'h10);
    wait_done(DONE_I_BIT, rd);
    chk(rd, 32'hC5);
    chk(32'(quad_coef), 32'h15);
    chk(32'(inphase_coef), 32'h15);
    wr(OFS_CAL_ACTION, 8'h02);
    rdchk(OFS_CAL_STATUS, 8'hC1);
    chk(32'(quad_coef), 32'h20);
    chk(32'(inphase_coef), 32'h15);
    wr(OFS_CAL_ACTION, 8'h01);
    chk(32'(inphase_coef), 32'h20);
    // Slow divider leaves time to see the run in progress
    wr(OFS_CAL_CONTROL, 8'h18);
    wr(OFS_CAL_ACTION, 8'h10);
    rdchk(OFS_CAL_STATUS, 8'h80);
    wait_done(DONE_I_BIT, rd);
    chk(32'(rd[DONE_I_BIT]), 32'h1);
    chk(32'(rd[3:0]), 32'h1);
    chk(32'(inphase_coef), 32'h20);
    chk(32'(quad_coef), 32'h20);
    // Done flags drop when cleared or when a launch selects their channel
    wr(OFS_CAL_ACTION, 8'hC0);
    rdchk(OFS_CAL_STATUS, 8'h01);
  endtask : test_cal

  task automatic test_tick;
    int n;
    int hits;
    wr(OFS_CAL_CONTROL, 8'h07);
    hits = 0;
    repeat (600) begin
      @(negedge clk);
      if (cal_tick === 1'b1) hits++;
    end
    chk(32'(hits), 32'h0);
    for (int d = 0; d < 8; d++) begin
      wr(OFS_CAL_CONTROL, {5'b00001, 3'(d)});
      n = 0;
      while (cal_tick !== 1'b1 && n < 600) begin
        @(negedge clk);
        n++;
      end
      @(negedge clk);
      n = 1;
      while (cal_tick !== 1'b1 && n < 600) begin
        @(negedge clk);
        n++;
      end
      chk(32'(n), 32'(256 >> d));
    end
    wr(OFS_CAL_CONTROL, 8'h00);
  endtask : test_tick

  task automatic test_unmapped;
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'b0, 10'h3FC, 8'h00, rd, rs);
    chk(rd, 32'h0);
    chk(32'(rs), 32'h3);
    bus(1'b1, 10'h3FC, 8'h5A, rd, rs);
    chk(32'(rs), 32'h3);
  endtask : test_unmapped

  // ----------------------------------------------------------------
  // Clock, reset, sequence and verdict
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Ceiling well above the roughly 2400 cycles the run needs
  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 40000) begin
      failures++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      finish_test();
    end
  end

  initial begin
    failures = 0;
    total_checks = 0;
    cycle_count = 0;
    resetn = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    test_reset();
    test_level();
    test_control();
    test_trim();
    test_store();
    test_cal();
    test_tick();
    test_unmapped();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
